// file: scc_consts.vh
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// Register indices; byte address is four times the index
`define SCC_IDX_CFG 12'h120
`define SCC_IDX_IGN 12'h121
`define SCC_IDX_WIN 12'h122
`define SCC_IDX_STAT 12'h124

// Capture configuration fields
`define SCC_CFG_FLAGRST 6
`define SCC_CFG_TRANS 4
`define SCC_CFG_EDGE 3
`define SCC_CFG_MODE_HI 2
`define SCC_CFG_MODE_LO 1
`define SCC_CFG_WMASK 8'h5e

// Ignore count field
`define SCC_IGN_WMASK 8'h0f

// Skew window fields
`define SCC_WIN_NEG_HI 3
`define SCC_WIN_NEG_LO 2
`define SCC_WIN_POS_HI 1
`define SCC_WIN_POS_LO 0
`define SCC_WIN_WMASK 8'h0f

// Status fields
`define SCC_STAT_SETUP 0
`define SCC_STAT_HOLD 1
`define SCC_STAT_ALIGNED 2
`define SCC_STAT_ARMED 3

// Capture modes
`define SCC_MODE_OFF 2'b00
`define SCC_MODE_CONT 2'b01
`define SCC_MODE_NSHOT 2'b10

// Reset value of every control field
`define SCC_RST_VAL 8'h00

`endif

// file: scc_sync.v
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser, one per bit
module scc_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q; // First stage, read by stage two only
  reg [W-1:0] stab_q; // Second stage, safe to use

  // Plain shift through both stages
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      stab_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      stab_q <= meta_q;
    end
  end

  assign sync_out = stab_q;

endmodule

`default_nettype wire

// file: scc_skew_chk.v
`timescale 1ns/10ps
`default_nettype none

// Classifies a transition against the expected phase zero
module scc_skew_chk #(
  parameter PERIOD = 16,
  parameter PW = 4
) (
  input wire [PW-1:0] phase,
  input wire [1:0] neg_win,
  input wire [1:0] pos_win,
  output reg exact,
  output reg early,
  output reg late,
  output reg in_win
);

  reg [PW-1:0] early_by; // Clocks before expected zero
  reg late_side; // Phase in first half means late

  // Late side: arrived phase clocks after zero; early side: before it
  always @* begin
    early_by = PERIOD[PW-1:0] - phase;
    late_side = (phase < PERIOD[PW:1]);
    exact = (phase == {PW{1'b0}});
    early = !exact && !late_side;
    late = !exact && late_side;
    if (exact) begin
      in_win = 1'b1;
    end else if (late_side) begin
      in_win = (phase <= {{(PW-2){1'b0}}, pos_win});
    end else begin
      in_win = (early_by <= {{(PW-2){1'b0}}, neg_win});
    end
  end

endmodule

`default_nettype wire

// file: scc_top.v
// What this block does
// - Flag-reset bit holds setup/hold flags cleared
// - Transition select: 0 rising, 1 falling valid
// - Edge select: capture on rising or falling clock
// - Mode 00 off, 01 continuous, 10 N-shot
// - N-shot ignores first n transitions, acts next
// - Negative window 00..10 ignores early by 0..2
// - Negative window 11 ignores early by three
// - Positive window ignores late by 0..3
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.vh"

module scc_top #(
  parameter PERIOD = 16, // Local frame clock period in sample clocks
  parameter PW = 4, // Phase counter width
  parameter AW = 14 // APB byte address width
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sysref_in,
  output reg sysref_align_q,
  output reg setup_err_q,
  output reg hold_err_q,
  output reg [PW-1:0] lmfc_phase_q
);

  // Software registers
  reg [7:0] cfg_q; // Capture configuration
  reg [7:0] ign_q; // N-shot ignore count
  reg [7:0] win_q; // Skew windows

  // Views only; every field is a plain slice of its register,
  // so a read returns exactly what the logic acts on
  // Field views
  wire flag_rst = cfg_q[`SCC_CFG_FLAGRST];
  wire trans_fall = cfg_q[`SCC_CFG_TRANS];
  wire edge_fall = cfg_q[`SCC_CFG_EDGE];
  wire [1:0] mode = cfg_q[`SCC_CFG_MODE_HI:`SCC_CFG_MODE_LO];
  wire [3:0] ign_n = ign_q[3:0];
  wire [1:0] neg_win = win_q[`SCC_WIN_NEG_HI:`SCC_WIN_NEG_LO];
  wire [1:0] pos_win = win_q[`SCC_WIN_POS_HI:`SCC_WIN_POS_LO];

  // Capture state
  reg neg_cap_q; // Pin sampled on the falling edge
  reg prev_q; // Last synchronised level, for edge finding
  reg [3:0] shot_cnt_q; // Transitions discarded so far
  reg armed_q; // N-shot still waiting for its shot
  reg aligned_q; // Phase counter has been set once

  // Writes commit only in the access cycle with pready high;
  // the address above bit 1 is a word index, and low address bits must be zero
  // APB decode
  wire setup_ph = psel && !penable;
  wire wr_done = psel && penable && pready && pwrite;
  wire [11:0] idx = paddr[AW-1:2];
  wire word_ok = (paddr[1:0] == 2'b00);
  wire hit_cfg = word_ok && (idx == `SCC_IDX_CFG);
  wire hit_ign = word_ok && (idx == `SCC_IDX_IGN);
  wire hit_win = word_ok && (idx == `SCC_IDX_WIN);
  wire hit_stat = word_ok && (idx == `SCC_IDX_STAT);
  wire hit_any = hit_cfg || hit_ign || hit_win || hit_stat;

  // The negedge flop only widens the choice of capture edge;
  // it feeds no logic directly, so the pin still meets two
  // rising-edge flops before the edge finder
  // Cost: the falling-edge path may lag the rising one by one
  // clock, which matters when the skew windows are sized
  // Falling-edge sampler; covered by the synchroniser below
  always @(negedge clk) begin
    if (rst) begin
      neg_cap_q <= 1'b0;
    end else begin
      neg_cap_q <= sysref_in;
    end
  end

  // One shared synchroniser keeps the two sample paths matched
  // in delay apart from the half cycle of the negedge flop
  // Both edge samples pass two flops before use
  wire [1:0] sync_lvl;

  scc_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({neg_cap_q, sysref_in}),
    .sync_out(sync_lvl)
  );

  // Pick the capturing clock edge
  wire cur_lvl = edge_fall ? sync_lvl[1] : sync_lvl[0];

  // Valid transition by polarity; a change of polarity while capture runs
  // cannot fake an edge, since rise and fall both come from the same level history
  wire rise = cur_lvl && !prev_q;
  wire fall = !cur_lvl && prev_q;
  wire valid_tr = trans_fall ? fall : rise;

  // Phase below half a frame counts as late, the rest as early;
  // the window fields decide how far either side is tolerated
  // Window classification of the current phase
  wire sk_exact;
  wire sk_early;
  wire sk_late;
  wire sk_in_win;

  scc_skew_chk #(
    .PERIOD(PERIOD),
    .PW(PW)
  ) u_skew (
    .phase(lmfc_phase_q),
    .neg_win(neg_win),
    .pos_win(pos_win),
    .exact(sk_exact),
    .early(sk_early),
    .late(sk_late),
    .in_win(sk_in_win)
  );

  // Code 11 has no defined meaning; treating it as off keeps a
  // stray write from starting capture unexpectedly
  // Mode decides whether this transition is acted on
  reg act;
  always @* begin
    case (mode)
      `SCC_MODE_CONT: begin
        act = valid_tr;
      end
      `SCC_MODE_NSHOT: begin
        act = valid_tr && armed_q && (shot_cnt_q == ign_n);
      end
      default: begin
        act = 1'b0; // Disabled; 11 treated as disabled too
      end
    endcase
  end

  // First capture always aligns; later ones only when outside the window
  wire realign = act && (!aligned_q || !sk_in_win);
  wire mis_early = act && aligned_q && sk_early && !sk_in_win;
  wire mis_late = act && aligned_q && sk_late && !sk_in_win;

  // Any write that selects N-shot re-arms the shot counter
  wire arm_wr = wr_done && hit_cfg &&
    (pwdata[`SCC_CFG_MODE_HI:`SCC_CFG_MODE_LO] == `SCC_MODE_NSHOT);

  // Masks drop reserved bits on the way in, so the read path
  // needs no extra gating for them
  // Register writes; masks keep reserved bits at zero
  always @(posedge clk) begin
    if (rst) begin
      cfg_q <= `SCC_RST_VAL;
      ign_q <= `SCC_RST_VAL;
      win_q <= `SCC_RST_VAL;
    end else if (wr_done) begin
      if (hit_cfg) begin
        cfg_q <= pwdata[7:0] & `SCC_CFG_WMASK;
      end
      if (hit_ign) begin
        ign_q <= pwdata[7:0] & `SCC_IGN_WMASK;
      end
      if (hit_win) begin
        win_q <= pwdata[7:0] & `SCC_WIN_WMASK;
      end
    end
  end

  // Tracks the selected level, not the raw pin; switching the edge
  // select while the pin is high could fake a transition, so that
  // change belongs in a period with capture off
  // Edge history follows the selected level
  always @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cur_lvl;
    end
  end

  // Counter moves only on valid transitions while armed; after the
  // shot the pin is ignored until software re-arms by writing the
  // mode field with N-shot again
  // Limitation: a new ignore count written mid-count is not guarded;
  // the compare simply uses the new value from then on
  // N-shot counting: discard n valid transitions, then fire once
  always @(posedge clk) begin
    if (rst) begin
      shot_cnt_q <= 4'h0;
      armed_q <= 1'b0;
    end else if (arm_wr) begin
      shot_cnt_q <= 4'h0;
      armed_q <= 1'b1;
    end else if (mode == `SCC_MODE_NSHOT && armed_q && valid_tr) begin
      if (shot_cnt_q == ign_n) begin
        armed_q <= 1'b0;
      end else begin
        shot_cnt_q <= shot_cnt_q + 4'h1;
      end
    end
  end

  // Realign loads one, not zero: the acting cycle itself is phase
  // zero, so the following cycle is phase one
  // The wrap compare truncates PERIOD to PW bits, so PERIOD must
  // not exceed two to the power PW
  // Frame phase counter; a realigning transition marks phase zero now
  always @(posedge clk) begin
    if (rst) begin
      lmfc_phase_q <= {PW{1'b0}};
      aligned_q <= 1'b0;
    end else if (realign) begin
      lmfc_phase_q <= (PERIOD == 1) ? {PW{1'b0}} : {{(PW-1){1'b0}}, 1'b1};
      aligned_q <= 1'b1;
    end else if (lmfc_phase_q == PERIOD[PW-1:0] - {{(PW-1){1'b0}}, 1'b1}) begin
      lmfc_phase_q <= {PW{1'b0}};
    end else begin
      lmfc_phase_q <= lmfc_phase_q + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // One-cycle pulse whenever the phase is reset
  always @(posedge clk) begin
    if (rst) begin
      sysref_align_q <= 1'b0;
    end else begin
      sysref_align_q <= realign;
    end
  end

  // Clear wins over a new error in the same cycle while the reset
  // bit is set; a flag latches only once the bit is back at zero
  // Errors come only from acted transitions outside the window
  // after the first alignment, never from the first capture
  // Sticky error flags; flag reset holds them clear
  always @(posedge clk) begin
    if (rst) begin
      setup_err_q <= 1'b0;
      hold_err_q <= 1'b0;
    end else if (flag_rst) begin
      setup_err_q <= 1'b0;
      hold_err_q <= 1'b0;
    end else begin
      setup_err_q <= setup_err_q || mis_early;
      hold_err_q <= hold_err_q || mis_late;
    end
  end

  // Status word: error flags, alignment done and N-shot armed;
  // reserved positions fall through as zero from the default
  // Read mux; unused upper bits read zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_cfg) begin
      rd_byte = cfg_q;
    end else if (hit_ign) begin
      rd_byte = ign_q;
    end else if (hit_win) begin
      rd_byte = win_q;
    end else if (hit_stat) begin
      rd_byte[`SCC_STAT_SETUP] = setup_err_q;
      rd_byte[`SCC_STAT_HOLD] = hold_err_q;
      rd_byte[`SCC_STAT_ALIGNED] = aligned_q;
      rd_byte[`SCC_STAT_ARMED] = armed_q;
    end
  end

  // Zero wait states: pready rises in the first access cycle and
  // drops after one cycle, so back-to-back transfers are fine
  // An unmapped or unaligned address answers with pslverr and
  // leaves every register untouched
  // APB slave: answer prepared in setup, so access completes at once;
  // registering the answer keeps every output a flop
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready <= 1'b1;
      pslverr <= !hit_any;
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: scc_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.vh"
// Port-level checker for the capture block
module scc_chk #(
  parameter PERIOD = 16,
  parameter PW = 4,
  parameter AW = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sysref_in,
  input wire logic sysref_align_q,
  input wire logic setup_err_q,
  input wire logic hold_err_q,
  input wire logic [PW-1:0] lmfc_phase_q
);
  logic [7:0] cfg_q; // Shadow of the config register
  // Follow completed config writes
  always_ff @(posedge clk) begin
    if (rst) cfg_q <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == 14'h480) cfg_q <= pwdata[7:0] & 8'h5e;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence setup_s; psel && !penable; endsequence
  // Six idle cycles flush any edge still in the synchroniser
  sequence off_s; (cfg_q[2:1] == 2'b00 || cfg_q[2:1] == 2'b11) [*6]; endsequence
  ready_next_a: assert property (setup_s |=> pready) else $error("pready late");
  ready_once_a: assert property (pready |=> !pready) else $error("pready held");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  bad_addr_a: assert property (setup_s and !(paddr inside {14'h480, 14'h484, 14'h488, 14'h490})
    |=> pslverr && prdata == 32'h00000000) else $error("unmapped not refused");
  align_once_a: assert property (sysref_align_q |=> !sysref_align_q) else $error("align held");
  align_phase_a: assert property (sysref_align_q |-> lmfc_phase_q == 1) else $error("phase not restarted");
  mode_off_a: assert property (off_s |=> !sysref_align_q) else $error("capture while off");
  flag_clear_a: assert property (cfg_q[6] |=> !setup_err_q && !hold_err_q) else $error("flags not held");
  setup_keep_a: assert property (setup_err_q && !cfg_q[6] |=> setup_err_q) else $error("setup flag lost");
  hold_keep_a: assert property (hold_err_q && !cfg_q[6] |=> hold_err_q) else $error("hold flag lost");
  reset_zero_a: assert property ($fell(rst) |-> !pready && !sysref_align_q && !setup_err_q && !hold_err_q
    && lmfc_phase_q == 0) else $error("outputs not reset");
endmodule
bind scc_top scc_chk #(.PERIOD(PERIOD), .PW(PW), .AW(AW)) chk (.*);
`default_nettype wire

// file: scc_sref_src.sv
`timescale 1ns/10ps
`default_nettype none
// External reference source: one four-cycle pulse per request
// With neg high the pulse is launched half a clock later, off the falling edge
module scc_sref_src (
  input wire logic clk,
  input wire logic go,
  input wire logic neg,
  output logic sysref
);
  logic [2:0] cnt_q = 3'h0; // High-time counter
  logic lag_q = 1'b0; // Same level, half a clock later
  // Level stays low between pulses, never floats
  always_ff @(posedge clk) cnt_q <= go ? 3'h4 : (cnt_q != 3'h0 ? cnt_q - 3'h1 : 3'h0);
  always_ff @(negedge clk) lag_q <= (cnt_q != 3'h0);
  assign sysref = neg ? lag_q : (cnt_q != 3'h0);
endmodule
`default_nettype wire

// file: sysref_capture_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scc_consts.vh"
module sysref_capture_control_tb_top;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, sneg = 0, err;
  logic [3:0] nv [3] = '{4'h0, 4'h3, 4'hf}; // Ignore counts for the N-shot runs
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sref, align, serr, herr;
  wire logic [3:0] phase;
  int failures = 0, samples_checked = 0, cyc = 0, aligns = 0, acyc = 0, fc, anc, a0;
  scc_top #(.PERIOD(16)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref_in(sref),
    .sysref_align_q(align), .setup_err_q(serr), .hold_err_q(herr), .lmfc_phase_q(phase));
  scc_sref_src src (.clk(clk), .go(go), .neg(sneg), .sysref(sref));
  always #12.5 clk = ~clk;
  // Cycle count, align monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (align === 1'b1) begin
      aligns <= aligns + 1;
      acyc <= cyc;
      chk(phase, 1);
    end
    if (cyc > 10000) begin
      failures = failures + 1;
      final_report;
    end
  end
  task final_report;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, then a gap cycle
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task rw(input logic [13:0] a, input logic [31:0] m);
    apb(0, a, 0);
    chk(rd, 0);
    apb(1, a, 32'hffffffff);
    apb(0, a, 0);
    chk(rd, m);
  endtask
  task fire;
    fc = cyc;
    go <= 1;
    @(posedge clk) go <= 0;
  endtask
  task wait_to(input int n);
    while (cyc < n) @(posedge clk);
  endtask
  // Realign far off phase with flags held, then one pulse d cycles off the frame;
  // nl launches that pulse off the falling edge
  task flagcase(input logic [7:0] cfg, input logic [7:0] win, input int d, input logic [1:0] ex,
    input logic nl = 1'b0);
    apb(1, 14'h480, 0);
    apb(1, 14'h488, win);
    apb(1, 14'h480, cfg | 8'h40);
    wait_to(anc + 88);
    fire;
    anc = fc;
    wait_to(anc + 20);
    apb(1, 14'h480, cfg);
    a0 = aligns;
    wait_to(anc + 32 + d);
    sneg <= nl;
    fire;
    repeat (12) @(posedge clk);
    sneg <= 1'b0;
    chk({herr, serr}, ex);
    chk(aligns - a0, ex != 0);
    apb(0, 14'h490, 0);
    chk(rd[1:0], ex);
    if (ex != 0) anc = fc;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rw(14'h480, 8'h5e);
    rw(14'h484, 8'h0f);
    rw(14'h488, 8'h0f);
    apb(0, 14'h48c, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(0, 14'h481, 0);
    chk(err, 1);
    anc = cyc;
    flagcase(8'h02, 8'h00, 0, 2'b00);
    flagcase(8'h02, 8'h00, 1, 2'b10);
    flagcase(8'h02, 8'h01, 1, 2'b00);
    flagcase(8'h02, 8'h03, 3, 2'b00);
    flagcase(8'h02, 8'h03, 4, 2'b10);
    flagcase(8'h02, 8'h00, -1, 2'b01);
    flagcase(8'h02, 8'h08, -2, 2'b00);
    flagcase(8'h02, 8'h08, -3, 2'b01);
    flagcase(8'h02, 8'h0c, -3, 2'b00);
    flagcase(8'h02, 8'h00, 0, 2'b00, 1);
    flagcase(8'h0a, 8'h00, 0, 2'b10, 1);
    flagcase(8'h0a, 8'h00, 1, 2'b10);
    flagcase(8'h12, 8'h00, -1, 2'b01);
    flagcase(8'h12, 8'h0c, 2, 2'b10);
    apb(1, 14'h480, 0);
    a0 = aligns;
    repeat (2) begin
      fire;
      repeat (16) @(posedge clk);
    end
    chk(aligns - a0, 0);
    foreach (nv[i]) begin
      apb(1, 14'h484, nv[i]);
      apb(1, 14'h480, 8'h04);
      a0 = aligns;
      anc = cyc + 2;
      for (int k = 0; k < nv[i] + 2; k++) begin
        wait_to(anc + 16 * k);
        fire;
      end
      repeat (12) @(posedge clk);
      chk(aligns - a0, 1);
      chk((acyc - anc - 16 * nv[i]) inside {[2:9]}, 1);
    end
    final_report;
  end
endmodule
`default_nettype wire
